// ### verilog/acp_pkg.sv
/*
  Constants for the alert / charge-done pin block of the charge gauge:
  register offsets, field positions, reset values and timing counts.
  Assumes a 20 MHz core clock and byte-wide register access.
*/
package acp_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [2:0] ACP_REG_STATUS = 3'h0;
  localparam logic [2:0] ACP_REG_CONTROL = 3'h1;
  localparam logic [2:0] ACP_REG_CHG_MSB = 3'h2;
  localparam logic [2:0] ACP_REG_CHG_LSB = 3'h3;
  localparam logic [2:0] ACP_REG_THR_HI_MSB = 3'h4;
  localparam logic [2:0] ACP_REG_THR_HI_LSB = 3'h5;
  localparam logic [2:0] ACP_REG_THR_LO_MSB = 3'h6;
  localparam logic [2:0] ACP_REG_THR_LO_LSB = 3'h7;
  // ==========================================================
  // Reset values and charge limits
  localparam logic [7:0] ACP_CONTROL_RST = 8'h3C;
  localparam logic [15:0] ACP_CHARGE_RST = 16'h7FFF;
  localparam logic [15:0] ACP_THR_HI_RST = 16'hFFFF;
  localparam logic [15:0] ACP_THR_LO_RST = 16'h0000;
  localparam logic [15:0] ACP_CHARGE_FULL = 16'hFFFF;
  localparam logic [15:0] ACP_CHARGE_EMPTY = 16'h0000;
  // Identification bit, value arbitrary
  localparam logic ACP_ID_BIT = 1'b1;
  // ==========================================================
  // Control field positions
  localparam int ACP_CTL_SHDN = 0;
  localparam int ACP_CTL_PIN_LO = 1;
  localparam int ACP_CTL_PIN_HI = 2;
  localparam int ACP_CTL_PRE_LO = 3;
  localparam int ACP_CTL_PRE_HI = 5;
  localparam int ACP_CTL_VBAT_LO = 6;
  localparam int ACP_CTL_VBAT_HI = 7;
  // Pin function codes
  localparam logic [1:0] ACP_PIN_OFF = 2'h0;
  localparam logic [1:0] ACP_PIN_CHG_DONE = 2'h1;
  localparam logic [1:0] ACP_PIN_ALERT = 2'h2;
  // Status bit positions
  localparam int ACP_ST_UVLO = 0;
  localparam int ACP_ST_VBAT = 1;
  localparam int ACP_ST_LOW = 2;
  localparam int ACP_ST_HIGH = 3;
  localparam int ACP_ST_OVF = 5;
  localparam int ACP_ST_ID = 7;
  // ==========================================================
  // Timing
  localparam int ACP_CLK_PERIOD_NS = 50;
  localparam int ACP_CHG_DONE_MIN_NS = 1000;
  localparam int ACP_CHG_DONE_CYC =
    (ACP_CHG_DONE_MIN_NS + ACP_CLK_PERIOD_NS - 1) / ACP_CLK_PERIOD_NS;
  localparam logic [4:0] ACP_CHG_DONE_LAST = 5'(ACP_CHG_DONE_CYC - 1);
endpackage

// ### verilog/acp_pin_ctrl.sv
/*
  Register file, charge accumulator with prescaler, threshold alerts
  and the shared alert / charge-done pin of a coulomb-counting gauge.
  Assumes a serial front end on the same clock that issues byte reads
  and writes, and an integrator that pulses ramp_up / ramp_down.
*/
`timescale 1ns/100ps
module acp_pin_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ramp_up,
  input wire logic ramp_down,
  input wire logic vbat_low_in,
  input wire logic uvlo_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  input wire logic scl_in,
  output logic scl_sync,
  input wire logic sda_in,
  output logic sda_sync,
  output logic sda_out,
  output logic sda_oe,
  input wire logic ser_tx_en,
  input wire logic ser_tx_bit,
  output logic [15:0] charge_level
);
  import acp_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] pin_meta;
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic [1:0] vbat_meta;
  logic [1:0] uvlo_meta;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta <= 2'h0;
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      vbat_meta <= 2'h0;
      uvlo_meta <= 2'h0;
    end else if (ce) begin
      pin_meta <= {pin_meta[0], pin_in};
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      vbat_meta <= {vbat_meta[0], vbat_low_in};
      uvlo_meta <= {uvlo_meta[0], uvlo_in};
    end
  end

  wire pin_level = pin_meta[1];
  wire vbat_low = vbat_meta[1];
  wire uvlo_seen = uvlo_meta[1];
  assign scl_sync = scl_meta[1];
  assign sda_sync = sda_meta[1];

  // ==========================================================
  // Serial data: open drain, clock never driven
  assign sda_out = 1'b0;
  assign sda_oe = ser_tx_en & ~ser_tx_bit;

  // ==========================================================
  // Registers
  logic [7:0] control;
  logic [15:0] charge;
  logic [15:0] thr_high;
  logic [15:0] thr_low;
  logic [6:0] prescale;
  logic [4:0] cc_count;
  logic flag_uvlo;
  logic flag_vbat;
  logic flag_low;
  logic flag_high;
  logic flag_ovf;

  wire [1:0] pin_mode = control[ACP_CTL_PIN_HI:ACP_CTL_PIN_LO];
  wire [2:0] pre_sel = control[ACP_CTL_PRE_HI:ACP_CTL_PRE_LO];
  wire shutdown = control[ACP_CTL_SHDN];
  wire mode_alert = (pin_mode == ACP_PIN_ALERT);
  wire mode_cc = (pin_mode == ACP_PIN_CHG_DONE);

  wire wr_ctl = reg_wr && (reg_addr == ACP_REG_CONTROL);
  wire wr_cmsb = reg_wr && (reg_addr == ACP_REG_CHG_MSB);
  wire wr_clsb = reg_wr && (reg_addr == ACP_REG_CHG_LSB);
  wire wr_hmsb = reg_wr && (reg_addr == ACP_REG_THR_HI_MSB);
  wire wr_hlsb = reg_wr && (reg_addr == ACP_REG_THR_HI_LSB);
  wire wr_lmsb = reg_wr && (reg_addr == ACP_REG_THR_LO_MSB);
  wire wr_llsb = reg_wr && (reg_addr == ACP_REG_THR_LO_LSB);
  wire rd_status = reg_rd && (reg_addr == ACP_REG_STATUS);

  // ==========================================================
  // Charge-done qualification: level must hold for the minimum width
  wire cc_hit = mode_cc && pin_level && (cc_count == ACP_CHG_DONE_LAST);
  wire [4:0] next_cc_count = (!mode_cc || !pin_level) ? 5'h00 :
    (cc_hit ? cc_count : cc_count + 5'h01);

  // ==========================================================
  // Prescaler: M = 2**sel, one charge count per M ramp reversals
  wire [6:0] pre_max = 7'((8'h01 << pre_sel) - 8'h01);
  wire at_full = (charge == ACP_CHARGE_FULL);
  wire at_empty = (charge == ACP_CHARGE_EMPTY);
  wire do_up = ramp_up && !ramp_down && !shutdown;
  wire do_down = ramp_down && !ramp_up && !shutdown;
  // A smaller M can leave prescale above the new top; count it as a wrap, not 128 steps
  wire step_up = do_up && (prescale >= pre_max);
  wire step_down = do_down && (prescale == 7'h00);
  wire [6:0] next_prescale = shutdown ? prescale :
    (do_up ? (step_up ? 7'h00 : prescale + 7'h01) :
    (do_down ? (step_down ? pre_max : prescale - 7'h01) : prescale));

  // Saturation instead of wrap; a reversal moves it off the limit
  wire [15:0] counted = (step_up && !at_full) ? charge + 16'h0001 :
    ((step_down && !at_empty) ? charge - 16'h0001 : charge);
  wire [15:0] written = {wr_cmsb ? reg_wdata : counted[15:8],
    wr_clsb ? reg_wdata : counted[7:0]};
  // Charger event wins over a software write in the same cycle
  wire [15:0] next_charge = cc_hit ? ACP_CHARGE_FULL : written;
  wire ovf_set = (step_up && at_full) || (step_down && at_empty);

  // ==========================================================
  // Threshold compare and sticky status, set wins over read clear
  wire high_cond = (charge > thr_high);
  wire low_cond = (charge < thr_low);
  wire vbat_cond = vbat_low && (control[ACP_CTL_VBAT_HI:ACP_CTL_VBAT_LO] != 2'h0);
  wire next_flag_high = high_cond || (flag_high && !rd_status);
  wire next_flag_low = low_cond || (flag_low && !rd_status);
  wire next_flag_ovf = ovf_set || ((at_full || at_empty) && flag_ovf) ||
    (flag_ovf && !rd_status);
  wire next_flag_vbat = vbat_cond || (flag_vbat && !rd_status);
  wire next_flag_uvlo = uvlo_seen || (flag_uvlo && !rd_status);
  wire any_alert = flag_high || flag_low || flag_ovf || flag_vbat;

  wire [7:0] status = {ACP_ID_BIT, 1'b0, flag_ovf, 1'b0, flag_high, flag_low,
    flag_vbat, flag_uvlo};

  always_ff @(posedge mclk) begin
    if (reset) begin
      control <= ACP_CONTROL_RST;
      thr_high <= ACP_THR_HI_RST;
      thr_low <= ACP_THR_LO_RST;
    end else if (ce) begin
      if (wr_ctl) control <= reg_wdata;
      if (wr_hmsb) thr_high[15:8] <= reg_wdata;
      if (wr_hlsb) thr_high[7:0] <= reg_wdata;
      if (wr_lmsb) thr_low[15:8] <= reg_wdata;
      if (wr_llsb) thr_low[7:0] <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      charge <= ACP_CHARGE_RST;
      prescale <= 7'h00;
      cc_count <= 5'h00;
    end else if (ce) begin
      charge <= next_charge;
      prescale <= next_prescale;
      cc_count <= next_cc_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flag_high <= 1'b0;
      flag_low <= 1'b0;
      flag_ovf <= 1'b0;
      flag_vbat <= 1'b0;
      flag_uvlo <= 1'b0;
    end else if (ce) begin
      flag_high <= next_flag_high;
      flag_low <= next_flag_low;
      flag_ovf <= next_flag_ovf;
      flag_vbat <= next_flag_vbat;
      flag_uvlo <= next_flag_uvlo;
    end
  end

  // ==========================================================
  // Read port: data only in the cycle after the strobe
  wire [7:0] read_mux = (reg_addr == ACP_REG_STATUS) ? status :
    (reg_addr == ACP_REG_CONTROL) ? control :
    (reg_addr == ACP_REG_CHG_MSB) ? charge[15:8] :
    (reg_addr == ACP_REG_CHG_LSB) ? charge[7:0] :
    (reg_addr == ACP_REG_THR_HI_MSB) ? thr_high[15:8] :
    (reg_addr == ACP_REG_THR_HI_LSB) ? thr_high[7:0] :
    (reg_addr == ACP_REG_THR_LO_MSB) ? thr_low[15:8] : thr_low[7:0];

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
    end
  end

  // ==========================================================
  // Shared pin: open drain in alert mode, released otherwise
  assign pin_out = 1'b0;
  assign pin_oe = mode_alert && any_alert;
  assign charge_level = charge;

  // ==========================================================
  // Assertions
  default clocking acp_cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_pin_mode_gate: assert property (pin_oe |-> pin_mode == ACP_PIN_ALERT)
    else $error("pin driven outside alert mode");
  a_reset_alert_mode: assert property ($past(reset) |-> mode_alert && !pin_oe)
    else $error("pin not in alert mode after reset");
  a_alert_pull_low: assert property (mode_alert && any_alert |-> pin_oe && !pin_out)
    else $error("alert not pulled low");
  a_cc_full_preset: assert property (ce && cc_hit |=> charge == ACP_CHARGE_FULL)
    else $error("charge not preset by charge done");
  a_cc_min_width: assert property (ce && cc_hit |-> $past(pin_level, 19))
    else $error("charge done accepted too early");
  a_prescale_step: assert property (ce && step_up && !at_full && !cc_hit && !wr_cmsb
    && !wr_clsb |=> charge == $past(charge) + 16'h0001)
    else $error("charge not stepped at prescaler wrap");
  a_sda_release: assert property (!ser_tx_en |-> !sda_oe && !sda_out)
    else $error("data line driven while idle");
  a_charge_read: assert property (ce && reg_rd && reg_addr == ACP_REG_CHG_MSB
    |=> reg_rdata == $past(charge[15:8]))
    else $error("charge upper byte read wrong");
  a_high_flag_set: assert property (ce && high_cond |=> flag_high)
    else $error("high alert flag missing");
  a_sat_top_hold: assert property (ce && at_full && !ramp_down && !reg_wr
    |=> charge == ACP_CHARGE_FULL)
    else $error("charge wrapped at top");
  a_cc_mode_only: assert property (ce && !mode_cc |=> cc_count == 5'h00)
    else $error("charge done acted on outside its mode");

  // ==========================================================
  // Count and flag checks
  a_low_flag_set: assert property (ce && low_cond |=> flag_low)
    else $error("low alert flag missing");
  a_sat_bottom_hold: assert property (ce && at_empty && !ramp_up && !reg_wr && !cc_hit
    |=> charge == ACP_CHARGE_EMPTY)
    else $error("charge wrapped at bottom");
  a_prescale_down: assert property (ce && step_down && !at_empty && !cc_hit && !wr_cmsb
    && !wr_clsb |=> charge == $past(charge) - 16'h0001)
    else $error("charge not stepped down at prescaler wrap");
  a_cc_count_clear: assert property (ce && !pin_level |=> cc_count == 5'h00)
    else $error("charge done count kept while pin low");
  a_pin_release: assert property (!any_alert |-> !pin_oe)
    else $error("pin pulled low with no alert");
  a_ovf_flag_set: assert property (ce && ovf_set |=> flag_ovf)
    else $error("overflow flag missing");
  // A low enable must hold the control register, not only the charge counter
  a_ce_freeze: assert property (!ce |=> charge == $past(charge) && control == $past(control))
    else $error("state moved while enable low");
  a_low_byte_read: assert property (ce && reg_rd && reg_addr == ACP_REG_CHG_LSB
    |=> reg_rdata == $past(charge[7:0]))
    else $error("charge lower byte read wrong");
  a_vbat_flag_set: assert property (ce && vbat_cond |=> flag_vbat)
    else $error("battery low flag missing");
  a_uvlo_flag_set: assert property (ce && uvlo_seen |=> flag_uvlo)
    else $error("undervoltage flag missing");
  a_high_read_clear: assert property (ce && rd_status && !high_cond |=> !flag_high)
    else $error("high flag not cleared by read");
  a_low_read_clear: assert property (ce && rd_status && !low_cond |=> !flag_low)
    else $error("low flag not cleared by read");
  a_cc_count_step: assert property (ce && mode_cc && pin_level && !cc_hit
    |=> cc_count == $past(cc_count) + 5'h01)
    else $error("charge done width count skipped");
  a_shutdown_hold: assert property (ce && shutdown && !reg_wr && !cc_hit
    |=> charge == $past(charge))
    else $error("charge counted in shutdown");
  a_ovf_read_clear: assert property (ce && rd_status && !ovf_set && !at_full && !at_empty
    |=> !flag_ovf)
    else $error("overflow flag not cleared by read");

  // ==========================================================
  // Cover points
  c_cc_preset: cover property (ce && cc_hit);
  c_alert_drive: cover property (pin_oe ##1 rd_status && ce);
  c_saturate: cover property (ce && ovf_set);
  c_low_alert: cover property (ce && low_cond);
  c_count_down: cover property (ce && step_down && !at_empty);
endmodule

// ### tb/acp_charger_model.sv
/*
  Charger at the far side of the shared alert / charge-done pin.
  Assumes an open-drain pin with a pull-up; the device only pulls low.
*/
`timescale 1ns/100ps
module acp_charger_model (
  input wire logic mclk,
  input wire logic pin_oe,
  output logic pin_level
);
  logic drv_en = 1'b0;
  logic drv_hi = 1'b0;
  // ==========================================================
  // Wire level
  // Device pull-down wins, then the charger, else the pull-up
  assign pin_level = pin_oe ? 1'b0 : (drv_en ? drv_hi : 1'b1);
  // ==========================================================
  // Charger actions
  task automatic drive(input logic en);
    @(posedge mclk);
    drv_en <= en;
    drv_hi <= 1'b0;
  endtask
  // Legal pulses last 20 cycles or more, i.e. at least 1 us at 50 ns
  task automatic pulse(input int n);
    @(posedge mclk);
    drv_hi <= 1'b1;
    repeat (n) @(posedge mclk);
    drv_hi <= 1'b0;
  endtask
endmodule

// ### tb/acp_pin_ctrl_bench.sv
/*
  Self-checking bench for the alert / charge-done pin block.
  Assumes the byte register port and the charger model beside it.
*/
`timescale 1ns/100ps
module acp_pin_ctrl_bench;
  import acp_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic ramp_up = 1'b0;
  logic ramp_down = 1'b0;
  logic tx_en = 1'b0;
  logic tx_bit = 1'b0;
  logic ce = 1'b1;
  logic vbat_in = 1'b0;
  logic uvlo_pin = 1'b0;
  logic scl = 1'b1;
  logic scl_s, sda_s;
  logic [15:0] chg_lvl;
  logic pin_level, pin_out, pin_oe, sda_out, sda_oe;
  logic [7:0] rd;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 mclk = ~mclk;
  acp_charger_model u_chg (.mclk(mclk), .pin_oe(pin_oe), .pin_level(pin_level));
  acp_pin_ctrl u_dut (.mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ramp_up(ramp_up), .ramp_down(ramp_down), .vbat_low_in(vbat_in), .uvlo_in(uvlo_pin),
    .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .scl_in(scl),
    .scl_sync(scl_s), .sda_in(~sda_oe), .sda_sync(sda_s), .sda_out(sda_out), .sda_oe(sda_oe),
    .ser_tx_en(tx_en), .ser_tx_bit(tx_bit), .charge_level(chg_lvl));
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdb(input logic [2:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
    rdb(a);
    chk($sformatf("reg %0d", a), {8'h00, exp}, {8'h00, rd});
  endtask
  task automatic chk_chg(input logic [15:0] exp);
    logic [15:0] v;
    rdb(ACP_REG_CHG_MSB);
    v[15:8] = rd;
    rdb(ACP_REG_CHG_LSB);
    v[7:0] = rd;
    chk("charge", exp, v);
  endtask
  task automatic set_chg(input logic [15:0] v);
    wr(ACP_REG_CHG_MSB, v[15:8]);
    wr(ACP_REG_CHG_LSB, v[7:0]);
  endtask
  task automatic ramp(input logic up, input int n);
    repeat (n) begin
      @(posedge mclk);
      ramp_up <= up;
      ramp_down <= ~up;
      @(posedge mclk);
      ramp_up <= 1'b0;
      ramp_down <= 1'b0;
    end
    repeat (3) @(posedge mclk);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("counts: %0d compared, %0d mismatched", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Hang guard, the tests need well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    chk_reg(ACP_REG_CONTROL, 8'h3C);
    chk_chg(16'h7FFF);
    chk_reg(ACP_REG_THR_HI_MSB, 8'hFF);
    chk_reg(ACP_REG_THR_LO_LSB, 8'h00);
    chk("pin drive", 16'h0000, {15'h0, pin_oe});
    $display("test reset done");
    wr(ACP_REG_THR_HI_MSB, 8'h80);
    wr(ACP_REG_THR_HI_LSB, 8'h00);
    pause(3);
    chk("pin drive", 16'h0000, {15'h0, pin_oe});
    wr(ACP_REG_CHG_MSB, 8'h90);
    pause(3);
    chk("pin level", 16'h0000, {14'h0, pin_out, pin_level});
    wr(ACP_REG_CHG_MSB, 8'h70);
    chk_reg(ACP_REG_STATUS, {ACP_ID_BIT, 7'h08});
    chk_reg(ACP_REG_STATUS, {ACP_ID_BIT, 7'h00});
    pause(2);
    chk("pin drive", 16'h0000, {15'h0, pin_oe});
    $display("test alert done");
    wr(ACP_REG_CONTROL, 8'h04);
    set_chg(16'h1000);
    ramp(1'b1, 3);
    ramp(1'b0, 1);
    chk_chg(16'h1002);
    wr(ACP_REG_CONTROL, 8'h0C);
    ramp(1'b1, 4);
    chk_chg(16'h1004);
    ramp(1'b1, 1);
    chk_chg(16'h1004);
    wr(ACP_REG_CONTROL, 8'h04);
    set_chg(16'hFFFF);
    ramp(1'b1, 2);
    chk_chg(16'hFFFF);
    ramp(1'b0, 1);
    chk_chg(16'hFFFE);
    set_chg(16'h0000);
    ramp(1'b0, 2);
    chk_chg(16'h0000);
    $display("test count done");
    pause(40);
    chk_chg(16'h0000);
    wr(ACP_REG_CONTROL, 8'h02);
    u_chg.drive(1'b1);
    set_chg(16'h1234);
    u_chg.pulse(10);
    pause(30);
    chk_chg(16'h1234);
    u_chg.pulse(ACP_CHG_DONE_CYC + 3);
    pause(4);
    chk_chg(ACP_CHARGE_FULL);
    chk("charge level", ACP_CHARGE_FULL, chg_lvl);
    chk("pin drive", 16'h0000, {15'h0, pin_oe});
    u_chg.drive(1'b0);
    wr(ACP_REG_CONTROL, 8'h00);
    pause(3);
    chk("pin drive", 16'h0000, {15'h0, pin_oe});
    wr(ACP_REG_CONTROL, 8'h04);
    pause(3);
    chk("pin drive", 16'h0001, {15'h0, pin_oe});
    $display("test charge done finished");
    @(posedge mclk);
    tx_en <= 1'b1;
    pause(1);
    chk("sda drive", 16'h0001, {15'h0, sda_oe});
    @(posedge mclk);
    tx_bit <= 1'b1;
    pause(1);
    chk("sda drive", 16'h0000, {14'h0, sda_out, sda_oe});
    @(posedge mclk);
    tx_en <= 1'b0;
    $display("test serial done");
    set_chg(16'h7FFF);
    chk_reg(ACP_REG_STATUS, 8'hA8);
    chk("charge level", 16'h7FFF, chg_lvl);
    wr(ACP_REG_CONTROL, 8'h44);
    @(posedge mclk);
    vbat_in <= 1'b1;
    uvlo_pin <= 1'b1;
    scl <= 1'b0;
    pause(4);
    chk("serial sync", 16'h0001, {14'h0, scl_s, sda_s});
    chk("pin drive", 16'h0001, {15'h0, pin_oe});
    @(posedge mclk);
    vbat_in <= 1'b0;
    uvlo_pin <= 1'b0;
    scl <= 1'b1;
    pause(4);
    chk_reg(ACP_REG_STATUS, 8'h83);
    chk_reg(ACP_REG_STATUS, 8'h80);
    chk("serial sync", 16'h0003, {14'h0, scl_s, sda_s});
    wr(ACP_REG_THR_LO_MSB, 8'h90);
    chk_reg(ACP_REG_STATUS, 8'h84);
    wr(ACP_REG_THR_LO_MSB, 8'h00);
    chk_reg(ACP_REG_STATUS, 8'h84);
    chk_reg(ACP_REG_STATUS, 8'h80);
    @(posedge mclk);
    ce <= 1'b0;
    wr(ACP_REG_CHG_MSB, 8'h11);
    ramp(1'b1, 2);
    @(posedge mclk);
    ce <= 1'b1;
    chk_chg(16'h7FFF);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    chk_reg(ACP_REG_CONTROL, 8'h3C);
    chk("pin drive", 16'h0000, {15'h0, pin_oe});
    $display("test inputs done");
    report_and_stop();
  end
endmodule
